// >>> rtl/rgd_pkg.sv
package rgd_pkg;

    // Register byte addresses
    localparam logic [7:0] RGD_ADDR_IF     = 8'h00;
    localparam logic [7:0] RGD_ADDR_CAL    = 8'h04;
    localparam logic [7:0] RGD_ADDR_GAIN   = 8'h08;
    localparam logic [7:0] RGD_ADDR_LEVEL  = 8'h0C;
    localparam logic [7:0] RGD_ADDR_SEQ    = 8'h10;
    localparam logic [7:0] RGD_ADDR_DEMOD  = 8'h14;
    localparam logic [7:0] RGD_ADDR_STATUS = 8'h18;

    // Field positions
    localparam int RGD_CAL_START_POS   = 9;
    localparam int RGD_GAIN_EN_POS     = 0;
    localparam int RGD_GAIN_MODE_POS   = 1;
    localparam int RGD_GAIN_FIELD_POS  = 2;
    localparam int RGD_GAIN_MIX_POS    = 4;
    localparam int RGD_GAIN_IFMAN_POS  = 5;
    localparam int RGD_LVL_REDUCE_POS  = 8;
    localparam int RGD_LVL_SETTLE_POS  = 16;
    localparam int RGD_DEMOD_BW_POS    = 2;
    localparam int RGD_ST_STRENGTH_POS = 1;
    localparam int RGD_ST_FRONT_POS    = 8;
    localparam int RGD_ST_IF_POS       = 10;
    localparam int RGD_ST_CAL_POS      = 12;

    // Values after reset
    localparam logic [1:0] RGD_BW_RST       = 2'h0;
    localparam logic [1:0] RGD_OFFDIV_RST   = 2'h0;
    localparam logic [8:0] RGD_CALDIV_RST   = 9'h000;
    localparam logic       RGD_GAIN_EN_RST  = 1'b1;
    localparam logic [1:0] RGD_AMP_GAIN_RST = 2'h3;
    localparam logic [1:0] RGD_IF_MAN_RST   = 2'h2;
    localparam logic [6:0] RGD_RAISE_RST    = 7'h1E;
    localparam logic [6:0] RGD_REDUCE_RST   = 7'h46;
    localparam logic [7:0] RGD_SETTLE_RST   = 8'h0A;
    localparam logic [7:0] RGD_SEQDIV_RST   = 8'h08;
    localparam logic [1:0] RGD_DSEL_RST     = 2'h1;
    localparam logic [9:0] RGD_PBW_RST      = 10'h009;

    // Strength converter has 80 levels
    localparam logic [6:0] RGD_STRENGTH_MAX = 7'h4F;
    // Gain ladder: five changes from highest to lowest
    localparam logic [2:0] RGD_LADDER_LAST  = 3'h5;

    // Demodulator selections
    localparam logic [1:0] RGD_DSEL_LINEAR = 2'h0;
    localparam logic [1:0] RGD_DSEL_CORR   = 2'h1;
    localparam logic [1:0] RGD_DSEL_AMPL   = 2'h2;

    // Calibration run time
    localparam int RGD_CLK_MHZ     = 250;
    localparam int RGD_CAL_TIME_US = 200;
    localparam int RGD_CAL_CYCLES  = RGD_CAL_TIME_US * RGD_CLK_MHZ;

    typedef enum logic [1:0] {
        RGD_ST_OFF   = 2'b00,
        RGD_ST_TRACK = 2'b01,
        RGD_ST_WAIT  = 2'b11
    } rgd_loop_e;

endpackage : rgd_pkg

// >>> rtl/rgd_rx_control.sv
`timescale 1ns/1ps
`default_nettype none

module rgd_rx_control
    import rgd_pkg::*;
#(
    parameter int CAL_CYCLES = RGD_CAL_CYCLES
)(
    input  wire logic               ref_clk_i,
    input  wire logic               rst_i,
    input  wire logic [7:0]         addr_i,
    input  wire logic [31:0]        wr_data_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic [31:0]             rd_data_o,
    input  wire logic [6:0]         strength_sample_i,
    input  wire logic signed [15:0] corr_plus_i,
    input  wire logic signed [15:0] corr_minus_i,
    input  wire logic signed [15:0] disc_i,
    output logic [1:0]              if_bandwidth_select_o,
    output logic [8:0]              calibration_divider_o,
    output logic                    cal_busy_o,
    output logic [1:0]              front_gain_state_o,
    output logic [1:0]              if_gain_state_o,
    output logic                    front_amp_mode_bit_o,
    output logic                    mixer_linearity_o,
    output logic                    offset_correction_clock_o,
    output logic                    data_o
);

    typedef struct packed {
        logic [1:0]         bw_sel;
        logic [1:0]         off_div;
        logic [8:0]         cal_div;
        logic               gain_en;
        logic               amp_mode;
        logic [1:0]         amp_gain;
        logic               mix_lin;
        logic [1:0]         if_man;
        logic [6:0]         raise_lvl;
        logic [6:0]         reduce_lvl;
        logic [7:0]         settle;
        logic [7:0]         seq_div;
        logic [1:0]         dsel;
        logic [9:0]         pbw;
        logic [15:0]        cal_cnt;
        logic               cal_busy;
        rgd_loop_e          st;
        logic [2:0]         gidx;
        logic [7:0]         pre;
        logic [7:0]         wcnt;
        logic [6:0]         strength;
        logic [1:0]         front;
        logic [1:0]         ifg;
        logic [3:0]         ocnt;
        logic               oclk;
        logic signed [15:0] y1;
        logic signed [15:0] y2;
        logic signed [15:0] avg;
        logic               data;
        logic [31:0]        rdata;
    } rgd_state_s;

    rgd_state_s s_reg;
    rgd_state_s s_next;

    // Front amp state per ladder step
    function automatic logic [1:0] ladder_front(input logic [2:0] i);
        unique case (i)
            3'h0:    ladder_front = 2'h3;
            3'h1,
            3'h2,
            3'h3:    ladder_front = 2'h2;
            3'h4:    ladder_front = 2'h1;
            default: ladder_front = 2'h0;
        endcase
    endfunction : ladder_front

    // IF gain state per ladder step
    function automatic logic [1:0] ladder_if(input logic [2:0] i);
        unique case (i)
            3'h0,
            3'h1:    ladder_if = 2'h2;
            3'h2:    ladder_if = 2'h1;
            default: ladder_if = 2'h0;
        endcase
    endfunction : ladder_if

    // One first-order low-pass step, coefficient k/1024
    function automatic logic signed [15:0] lpf_step(
        input logic signed [15:0] y,
        input logic signed [15:0] x,
        input logic [9:0]         k
    );
        logic signed [16:0] d;
        logic signed [27:0] p;
        d = 17'(x) - 17'(y);
        p = 28'(d) * $signed({1'b0, k});
        lpf_step = 16'(17'(y) + 17'(p >>> 10));
    endfunction : lpf_step

    // Half period of the offset clock in input cycles, minus one
    function automatic logic [3:0] off_half(input logic [1:0] f);
        unique case (f)
            2'h0:    off_half = 4'h1;
            2'h1:    off_half = 4'h3;
            default: off_half = 4'h7;
        endcase
    endfunction : off_half

    logic signed [16:0] corr_diff;
    logic signed [15:0] demod_in;
    logic               step_done;
    logic [7:0]         seq_div_eff;
    logic [7:0]         settle_eff;

    always_comb
    begin
        s_next = s_reg;
        s_next.rdata = 32'h0000_0000;
        seq_div_eff = (s_reg.seq_div == 8'h00) ? 8'h01 : s_reg.seq_div;
        settle_eff  = (s_reg.settle == 8'h00) ? 8'h01 : s_reg.settle;
        step_done = (s_reg.pre + 8'h01) >= seq_div_eff;

        if (s_reg.cal_cnt != 16'h0000)
        begin
            s_next.cal_cnt = s_reg.cal_cnt - 16'h0001;
        end
        s_next.cal_busy = (s_next.cal_cnt != 16'h0000);

        if (wr_i)
        begin
            unique case (addr_i)
                RGD_ADDR_IF:
                begin
                    s_next.bw_sel  = wr_data_i[1:0];
                    s_next.off_div = wr_data_i[3:2];
                end
                RGD_ADDR_CAL:
                begin
                    s_next.cal_div = wr_data_i[8:0];
                    if (wr_data_i[RGD_CAL_START_POS])
                    begin
                        s_next.cal_cnt  = 16'(CAL_CYCLES);
                        s_next.cal_busy = 1'b1;
                    end
                end
                RGD_ADDR_GAIN:
                begin
                    s_next.gain_en  = wr_data_i[RGD_GAIN_EN_POS];
                    s_next.amp_mode = wr_data_i[RGD_GAIN_MODE_POS];
                    s_next.amp_gain = wr_data_i[RGD_GAIN_FIELD_POS +: 2];
                    s_next.mix_lin  = wr_data_i[RGD_GAIN_MIX_POS];
                    s_next.if_man   = wr_data_i[RGD_GAIN_IFMAN_POS +: 2];
                end
                RGD_ADDR_LEVEL:
                begin
                    s_next.raise_lvl  = wr_data_i[6:0];
                    s_next.reduce_lvl = wr_data_i[RGD_LVL_REDUCE_POS +: 7];
                    s_next.settle     = wr_data_i[RGD_LVL_SETTLE_POS +: 8];
                end
                RGD_ADDR_SEQ:
                begin
                    s_next.seq_div = wr_data_i[7:0];
                end
                RGD_ADDR_DEMOD:
                begin
                    s_next.dsel = wr_data_i[1:0];
                    s_next.pbw  = wr_data_i[RGD_DEMOD_BW_POS +: 10];
                end
                default:
                begin
                end
            endcase
        end

        if (rd_i)
        begin
            unique case (addr_i)
                RGD_ADDR_IF:
                    s_next.rdata = {28'h0, s_reg.off_div, s_reg.bw_sel};
                RGD_ADDR_CAL:
                    s_next.rdata = {23'h0, s_reg.cal_div};
                RGD_ADDR_GAIN:
                    s_next.rdata = {25'h0, s_reg.if_man, s_reg.mix_lin,
                                    s_reg.amp_gain, s_reg.amp_mode,
                                    s_reg.gain_en};
                RGD_ADDR_LEVEL:
                    s_next.rdata = {8'h0, s_reg.settle, 1'b0,
                                    s_reg.reduce_lvl, 1'b0, s_reg.raise_lvl};
                RGD_ADDR_SEQ:
                    s_next.rdata = {24'h0, s_reg.seq_div};
                RGD_ADDR_DEMOD:
                    s_next.rdata = {20'h0, s_reg.pbw, s_reg.dsel};
                RGD_ADDR_STATUS:
                    s_next.rdata = {19'h0, s_reg.cal_busy, s_reg.ifg,
                                    s_reg.front, s_reg.strength, 1'b0};
                default:
                    s_next.rdata = 32'h0000_0000;
            endcase
        end

        s_next.strength = (strength_sample_i > RGD_STRENGTH_MAX)
                        ? RGD_STRENGTH_MAX : strength_sample_i;

        unique case (s_reg.st)
            RGD_ST_OFF:
            begin
                if (s_reg.gain_en)
                begin
                    s_next.st = RGD_ST_TRACK;
                end
            end
            RGD_ST_TRACK:
            begin
                if (s_reg.strength > s_reg.reduce_lvl &&
                    s_reg.gidx != RGD_LADDER_LAST)
                begin
                    s_next.gidx = s_reg.gidx + 3'h1;
                    s_next.st   = RGD_ST_WAIT;
                    s_next.pre  = 8'h00;
                    s_next.wcnt = 8'h00;
                end
                else if (s_reg.strength < s_reg.raise_lvl &&
                         s_reg.gidx != 3'h0)
                begin
                    s_next.gidx = s_reg.gidx - 3'h1;
                    s_next.st   = RGD_ST_WAIT;
                    s_next.pre  = 8'h00;
                    s_next.wcnt = 8'h00;
                end
            end
            RGD_ST_WAIT:
            begin
                if (step_done)
                begin
                    s_next.pre = 8'h00;
                    if ((s_reg.wcnt + 8'h01) >= settle_eff)
                    begin
                        s_next.st = RGD_ST_TRACK;
                    end
                    else
                    begin
                        s_next.wcnt = s_reg.wcnt + 8'h01;
                    end
                end
                else
                begin
                    s_next.pre = s_reg.pre + 8'h01;
                end
            end
            default:
            begin
                s_next.st = RGD_ST_OFF;
            end
        endcase
        if (!s_reg.gain_en)
        begin
            s_next.st = RGD_ST_OFF;
        end

        if (s_reg.gain_en)
        begin
            s_next.front = ladder_front(s_next.gidx);
            s_next.ifg   = ladder_if(s_next.gidx);
        end
        else
        begin
            s_next.front = s_reg.amp_gain;
            s_next.ifg   = s_reg.if_man;
        end

        if (s_reg.ocnt >= off_half(s_reg.off_div))
        begin
            s_next.ocnt = 4'h0;
            s_next.oclk = ~s_reg.oclk;
        end
        else
        begin
            s_next.ocnt = s_reg.ocnt + 4'h1;
        end

        corr_diff = 17'(corr_plus_i) - 17'(corr_minus_i);
        unique case (s_reg.dsel)
            RGD_DSEL_CORR:
                demod_in = (corr_diff > 17'sd32767) ? 16'sh7FFF
                         : (corr_diff < -17'sd32768) ? 16'sh8000
                         : 16'(corr_diff);
            RGD_DSEL_AMPL:
                demod_in = $signed({9'h000, s_reg.strength});
            default:
                demod_in = disc_i;
        endcase
        s_next.y1  = lpf_step(s_reg.y1, demod_in, s_reg.pbw);
        s_next.y2  = lpf_step(s_reg.y2, s_reg.y1, s_reg.pbw);
        s_next.avg = lpf_step(s_reg.avg, s_reg.y2, s_reg.pbw >> 4);
        if (s_reg.dsel == RGD_DSEL_CORR)
        begin
            s_next.data = (s_reg.y2 > 16'sh0000);
        end
        else
        begin
            s_next.data = (s_reg.y2 > s_reg.avg);
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            s_reg            <= '0;
            s_reg.bw_sel     <= RGD_BW_RST;
            s_reg.off_div    <= RGD_OFFDIV_RST;
            s_reg.cal_div    <= RGD_CALDIV_RST;
            s_reg.gain_en    <= RGD_GAIN_EN_RST;
            s_reg.amp_gain   <= RGD_AMP_GAIN_RST;
            s_reg.if_man     <= RGD_IF_MAN_RST;
            s_reg.raise_lvl  <= RGD_RAISE_RST;
            s_reg.reduce_lvl <= RGD_REDUCE_RST;
            s_reg.settle     <= RGD_SETTLE_RST;
            s_reg.seq_div    <= RGD_SEQDIV_RST;
            s_reg.dsel       <= RGD_DSEL_RST;
            s_reg.pbw        <= RGD_PBW_RST;
            s_reg.st         <= RGD_ST_OFF;
            s_reg.front      <= 2'h3;
            s_reg.ifg        <= 2'h2;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign rd_data_o                 = s_reg.rdata;
    assign if_bandwidth_select_o     = s_reg.bw_sel;
    assign calibration_divider_o     = s_reg.cal_div;
    assign cal_busy_o                = s_reg.cal_busy;
    assign front_gain_state_o        = s_reg.front;
    assign if_gain_state_o           = s_reg.ifg;
    assign front_amp_mode_bit_o      = s_reg.amp_mode;
    assign mixer_linearity_o         = s_reg.mix_lin;
    assign offset_correction_clock_o = s_reg.oclk;
    assign data_o                    = s_reg.data;

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    cal_start_busy_a: assert property (
        wr_i && addr_i == RGD_ADDR_CAL && wr_data_i[RGD_CAL_START_POS]
        |=> cal_busy_o [*8])
        else $error("calibration did not stay busy");
    bw_follow_a: assert property (
        wr_i && addr_i == RGD_ADDR_IF
        |=> if_bandwidth_select_o == $past(wr_data_i[1:0]))
        else $error("bandwidth select not updated");
    manual_gain_a: assert property (
        !s_reg.gain_en && !$past(s_reg.gain_en)
        |-> if_gain_state_o == $past(s_reg.if_man))
        else $error("manual IF gain not applied");
    reduce_gain_a: assert property (
        s_reg.st == RGD_ST_TRACK && s_reg.gain_en &&
        s_reg.strength > s_reg.reduce_lvl && s_reg.gidx != 3'h5
        |=> s_reg.gidx == $past(s_reg.gidx) + 3'h1)
        else $error("gain not reduced above level");
    wait_hold_a: assert property (
        s_reg.st == RGD_ST_TRACK && s_next.st == RGD_ST_WAIT
        |=> s_reg.st == RGD_ST_WAIT [*2])
        else $error("loop acted during settle wait");
    ladder_max_a: assert property (
        s_reg.gidx <= RGD_LADDER_LAST)
        else $error("ladder index out of range");
    strength_max_a: assert property (
        rd_i && addr_i == RGD_ADDR_STATUS
        |=> rd_data_o[7:1] <= RGD_STRENGTH_MAX)
        else $error("strength code above 79");
    zero_slice_a: assert property (
        s_reg.dsel == RGD_DSEL_CORR && $stable(s_reg.dsel)
        |=> data_o == ($past(s_reg.y2) > 16'sh0000))
        else $error("correlator slicer not at zero");
    offset_clk_a: assert property (
        $rose(offset_correction_clock_o) && s_reg.off_div == 2'h0 &&
        !(wr_i && addr_i == RGD_ADDR_IF)
        |=> offset_correction_clock_o ##1 !offset_correction_clock_o)
        else $error("offset clock divide by 4 wrong");

    gain_step_c: cover property (s_reg.st == RGD_ST_WAIT);
    cal_done_c:  cover property ($fell(cal_busy_o));
    corr_data_c: cover property (s_reg.dsel == RGD_DSEL_CORR && $rose(data_o));

endmodule : rgd_rx_control

`default_nettype wire

// >>> sim/rgd_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module rgd_host_model #(
    parameter int CAL_CYCLES = 20
)(
    input  wire logic  ref_clk_i,
    output logic [7:0]  addr_o,
    output logic [31:0] wr_data_o,
    output logic        wr_o,
    output logic        rd_o
);
    initial
    begin
        addr_o = 8'h00;
        wr_data_o = 32'h00000000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // One-cycle write strobe, idle cycle after
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_o    <= a;
        wr_data_o <= d;
        wr_o      <= 1'b1;
        @(posedge ref_clk_i);
        wr_o      <= 1'b0;
        @(posedge ref_clk_i);
    endtask : wr

    // One-cycle read strobe; data stands in the next cycle
    task automatic rd(input logic [7:0] a);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge ref_clk_i);
        rd_o   <= 1'b0;
        @(posedge ref_clk_i);
    endtask : rd

    // stay off the bus while calibrating
    task automatic cal(input logic [8:0] div);
        wr(8'h04, {22'h000000, 1'b1, div});
        repeat (CAL_CYCLES + 2) @(posedge ref_clk_i);
    endtask : cal

    // wait 25 x 250 cycles, 25 us
    task automatic setup();
        wr(8'h0C, {8'h00, 8'h19, 1'b0, 7'h46, 1'b0, 7'h1E});
        wr(8'h10, 32'h000000FA);
    endtask : setup
endmodule : rgd_host_model

`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import rgd_pkg::*;
    localparam int CAL = 20;
    localparam int WT  = 6250;
    logic               clk;
    logic               rst;
    logic [7:0]         addr;
    logic [31:0]        wdata;
    logic               wr;
    logic               rd;
    logic [31:0]        rdata;
    logic [6:0]         strength;
    logic signed [15:0] cplus;
    logic signed [15:0] cminus;
    logic signed [15:0] disc;
    logic [1:0]         bw;
    logic [1:0]         front;
    logic [1:0]         ifg;
    logic [8:0]         cdiv;
    logic               busy;
    logic               amode;
    logic               mix;
    logic               oclk;
    logic               dout;
    logic               rd_seen = 1'b0;
    logic               gain_on;
    logic [31:0]        exp_q[$];
    logic [3:0]         chg_q[$];
    int                 gap_q[$];
    logic [3:0]         lad [6] = '{4'hE, 4'hA, 4'h9, 4'h8, 4'h4, 4'h0};
    int                 miscompares = 0;
    int                 total_checks = 0;
    int                 busy_cnt = 0;
    int                 cyc = 0;
    int                 seed = 93;
    int                 r;
    logic [8:0]         rv;
    logic [1:0]         g;
    logic [1:0]         i2;
    logic               m;
    logic               x;

    rgd_host_model #(.CAL_CYCLES(CAL)) u_host (.ref_clk_i(clk), .addr_o(addr),
        .wr_data_o(wdata), .wr_o(wr), .rd_o(rd));

    rgd_rx_control #(.CAL_CYCLES(CAL)) u_dut (.ref_clk_i(clk), .rst_i(rst),
        .addr_i(addr), .wr_data_i(wdata), .wr_i(wr), .rd_i(rd),
        .rd_data_o(rdata), .strength_sample_i(strength), .corr_plus_i(cplus),
        .corr_minus_i(cminus), .disc_i(disc), .if_bandwidth_select_o(bw),
        .calibration_divider_o(cdiv), .cal_busy_o(busy),
        .front_gain_state_o(front), .if_gain_state_o(ifg),
        .front_amp_mode_bit_o(amode), .mixer_linearity_o(mix),
        .offset_correction_clock_o(oclk), .data_o(dout));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        u_host.rd(a);
    endtask : rdx

    task automatic rises(output int n);
        logic po;
        n = 0;
        repeat (20) @(posedge clk);
        po = oclk;
        repeat (64)
        begin
            @(posedge clk);
            if (oclk === 1'b1 && po === 1'b0)
                n++;
            po = oclk;
        end
    endtask : rises

    task automatic waitn(input int n);
        int k;
        k = 0;
        while (chg_q.size() < n && k < 40000)
        begin
            @(posedge clk);
            k++;
        end
    endtask : waitn

    task automatic complete_run();
        $display("total_checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    always @(posedge clk)
    begin
        cyc++;
        if (busy === 1'b1)
            busy_cnt++;
        if (rd_seen)
            chk(rdata, exp_q.pop_front());
        rd_seen <= rd;
    end

    always @(front or ifg)
    begin
        if (gain_on)
        begin
            chg_q.push_back({front, ifg});
            gap_q.push_back(cyc);
        end
    end

    initial
    begin
        #(360000);
        miscompares++;
        complete_run();
    end

    initial
    begin
        rst = 1'b1;
        gain_on = 1'b0;
        strength = 7'd50;
        cplus = 16'sd0;
        cminus = 16'sd0;
        disc = 16'sd0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdx(RGD_ADDR_STATUS, 32'h00000B64);
        rdx(8'h1C, 32'h00000000);
        $display("test reset done");
        for (int d = 0; d < 3; d++)
        begin
            u_host.wr(RGD_ADDR_IF, {28'h0, d[1:0], d[1:0]});
            chk({30'h0, bw}, {30'h0, d[1:0]});
            rises(r);
            chk(r, 16 >> d);
        end
        $display("test dividers done");
        rv = 9'($random(seed));
        u_host.cal(rv);
        chk({23'h0, cdiv}, {23'h0, rv});
        chk(busy_cnt, CAL);
        $display("test calibration done");
        u_host.setup();
        gain_on = 1'b1;
        strength <= 7'h7F;
        waitn(5);
        repeat (20) @(posedge clk);
        rdx(RGD_ADDR_STATUS, {24'h0, RGD_STRENGTH_MAX, 1'b0});
        strength <= 7'h00;
        waitn(10);
        repeat (WT + 50) @(posedge clk);
        chk(chg_q.size(), 10);
        for (int i = 0; i < 10; i++)
        begin
            int gp;
            gp = (i == 0) ? 0 : gap_q[i] - gap_q[i - 1];
            chk(32'(chg_q[i]), 32'(lad[(i < 5) ? i + 1 : 9 - i]));
            if (i != 0 && i != 5)
                chk(gp >= WT && gp <= WT + 6, 1);
        end
        $display("test gain loop done");
        gain_on = 1'b0;
        strength <= 7'h7F;
        repeat (3)
        begin
            g = 2'($random(seed));
            i2 = 2'($unsigned($random(seed)) % 3);
            m = 1'($random(seed));
            x = 1'($random(seed));
            u_host.wr(RGD_ADDR_GAIN, {25'h0, i2, x, g, m, 1'b0});
            repeat (100) @(posedge clk);
            chk(32'({amode, mix, front, ifg}), 32'({m, x, g, i2}));
        end
        rdx(RGD_ADDR_STATUS, {19'h0, 1'b0, i2, g, 7'h4F, 1'b0});
        $display("test manual gain done");
        u_host.wr(RGD_ADDR_DEMOD, {20'h0, 10'h3FF, RGD_DSEL_CORR});
        cplus <= 16'sd1000;
        cminus <= -16'sd1000;
        repeat (60) @(posedge clk);
        chk({31'h0, dout}, 32'h1);
        cplus <= -16'sd1000;
        cminus <= 16'sd1000;
        repeat (60) @(posedge clk);
        chk({31'h0, dout}, 32'h0);
        u_host.wr(RGD_ADDR_DEMOD, {20'h0, 10'h3FF, RGD_DSEL_LINEAR});
        disc <= -16'sd1000;
        repeat (300) @(posedge clk);
        disc <= 16'sd1000;
        repeat (6) @(posedge clk);
        chk({31'h0, dout}, 32'h1);
        disc <= -16'sd1000;
        repeat (6) @(posedge clk);
        chk({31'h0, dout}, 32'h0);
        u_host.wr(RGD_ADDR_DEMOD, {20'h0, 10'h3FF, RGD_DSEL_AMPL});
        strength <= 7'h00;
        repeat (300) @(posedge clk);
        strength <= 7'h4F;
        repeat (6) @(posedge clk);
        chk({31'h0, dout}, 32'h1);
        strength <= 7'h00;
        repeat (6) @(posedge clk);
        chk({31'h0, dout}, 32'h0);
        $display("test demodulator done");
        repeat (4) @(posedge clk);
        complete_run();
    end
endmodule : tb

`default_nettype wire
